// *** hdl/afs_pkg.sv ***
// Purpose: Constants shared by the amplifier fault supervisor.
// Assumes: 125 MHz mclk_i, APB register access with 32-bit data.
// Notes: Register offsets are byte addresses.
package afs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned RETRY_MS = 100;
  localparam int unsigned RETRY_CYC = RETRY_MS * CLK_KHZ;
  localparam int unsigned SOFT_MUTE_US = 10;
  localparam int unsigned SOFT_MUTE_CYC = (SOFT_MUTE_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned CNT_W = 24;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FAULT_STICKY = 8'h00;
  localparam logic [7:0] ADDR_INT_MASK = 8'h04;
  localparam logic [7:0] ADDR_PWR_CTRL_1 = 8'h08;
  localparam logic [7:0] ADDR_SECOND_POWER_CONTROL_REG = 8'h0c;
  localparam logic [7:0] ADDR_PROT_CFG = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // Fault sticky and interrupt mask bit positions
  localparam int unsigned BIT_CLK_A = 5;
  localparam int unsigned BIT_OVERTEMP = 4;
  localparam int unsigned BIT_BROWNOUT = 3;
  localparam int unsigned BIT_CLK_B = 2;
  localparam int unsigned BIT_UNDERVOLT = 1;
  localparam logic [7:0] STICKY_USED = 8'h3e;

  // Protection config bit positions
  localparam int unsigned BIT_CLKA_DET_EN = 0;
  localparam int unsigned BIT_CLKB_DET_EN = 1;
  localparam int unsigned BIT_OT_RETRY_DIS = 2;

  // Reset values
  localparam logic [7:0] RST_INT_MASK = 8'h00;
  localparam logic [2:0] RST_PROT_CFG = 3'h3;

  // ----------------------------------------------------------------
  // Supervisor states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_RUN = 5'b00010,
    ST_MUTE = 5'b00100,
    ST_RETRY = 5'b01000,
    ST_HOLD = 5'b10000
  } afs_state_type;

endpackage

// *** hdl/afs_fault_if.sv ***
// Purpose: Carrier between the fault detector and the supervisor core.
// Assumes: All signals in the mclk_i domain.
// Notes: Levels are synchronised; events are one-cycle rising edges.
`timescale 1ns/1ps
interface afs_fault_if;
  logic uv_lvl;
  logic ot_lvl;
  logic bo_lvl;
  logic clka_lvl;
  logic clkb_lvl;
  logic uv_evt;
  logic bo_evt;
  logic clka_evt;
  logic clkb_evt;
  logic clka_en;
  logic clkb_en;

  modport det (
    output uv_lvl, ot_lvl, bo_lvl, clka_lvl, clkb_lvl,
    output uv_evt, bo_evt, clka_evt, clkb_evt,
    input clka_en, clkb_en
  );
  modport ctl (
    input uv_lvl, ot_lvl, bo_lvl, clka_lvl, clkb_lvl,
    input uv_evt, bo_evt, clka_evt, clkb_evt,
    output clka_en, clkb_en
  );
endinterface

// *** hdl/afs_fault_detect.sv ***
// Purpose: Synchronise analog and clock monitor fault pins, make edges.
// Assumes: Monitor pins are asynchronous to mclk_i.
// Notes: Clock error detectors are gated by their enables.
`timescale 1ns/1ps
module afs_fault_detect
  import afs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic vdd_low_i,
  input wire logic vbat_low_i,
  input wire logic overtemp_i,
  input wire logic brownout_i,
  input wire logic asi_clk_err_i,
  input wire logic int_clk_err_i,
  afs_fault_if.det flt
);

  logic [5:0] raw;
  logic [5:0] meta_r;
  logic [5:0] sync_r;
  logic [5:0] prev_r;
  logic [5:0] rise;

  assign raw = {int_clk_err_i, asi_clk_err_i, brownout_i, overtemp_i, vbat_low_i, vdd_low_i};

  // ----------------------------------------------------------------
  // Two-stage synchroniser and edge history
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      meta_r <= 6'h00;
      sync_r <= 6'h00;
      prev_r <= 6'h00;
    end else if (ce_i) begin
      meta_r <= raw;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign rise = sync_r & ~prev_r & {6{ce_i}};

  assign flt.uv_lvl = sync_r[0] | sync_r[1];
  assign flt.uv_evt = rise[0] | rise[1];
  assign flt.ot_lvl = sync_r[2];
  assign flt.bo_lvl = sync_r[3];
  assign flt.bo_evt = rise[3];
  assign flt.clka_lvl = sync_r[4] & flt.clka_en;
  assign flt.clka_evt = rise[4] & flt.clka_en;
  assign flt.clkb_lvl = sync_r[5] & flt.clkb_en;
  assign flt.clkb_evt = rise[5] & flt.clkb_en;

endmodule

// *** hdl/afs_supervisor.sv ***
// Purpose: Fault supervisor for a boosted class-D amplifier, APB slave.
// Assumes: Fault pins come from analog comparators and clock monitors.
// Notes: Sticky flags clear on read; one wait state on every access.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps

// Contract
// - Under-voltage fault when core supply below 1.5 V or battery below 2.4 V.
// - Under-voltage disables audio and powers down class-D stage.
// - Under-voltage sets sticky flag, cleared by read or reset.
// - Over-temperature watched while class-D powered; trips audio and class-D off.
// - Auto-retry re-powers class-D every 100 ms, shuts again if still hot.
// - Retry-disable bit: 0 retries (default), 1 no retry.
// - Over-temperature sets sticky flag, cleared by read or reset.
// - Enabled serial port clock error soft-mutes, then stops class-D and core.
// - Internal clock error soft-mutes, then powers down class-D.
// - Brownout soft-mutes, powers down core, dividers, analog; sets power error.
// - Brownout sets sticky bit 3, cleared by read or reset.
// - Power error bit 0 of second power control: 1 means powered down.
// - Under-voltage, over-temperature and brownout usable as interrupt sources.
// - Brownout flag cleared by read like other flags.
// - Enabled sticky flags ORed onto interrupt output.
module afs_supervisor
  import afs_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = RETRY_CYC
)(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic vdd_low_i,
  input wire logic vbat_low_i,
  input wire logic overtemp_i,
  input wire logic brownout_i,
  input wire logic asi_clk_err_i,
  input wire logic int_clk_err_i,
  output logic classd_en_o,
  output logic audio_mute_o,
  output logic core_en_o,
  output logic analog_en_o,
  output logic irq_o
);

  afs_fault_if flt ();

  afs_state_type state_r;
  afs_state_type state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [7:0] sticky_r;
  logic [7:0] mask_r;
  logic device_power_field_r;
  logic power_error_field_r;
  logic [2:0] prot_r;
  logic [31:0] rdata_r;
  logic wait_r;
  logic cause_bo_r;
  logic cause_clka_r;
  logic classd_r;
  logic mute_r;
  logic core_r;
  logic analog_r;
  logic irq_r;

  logic access;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [7:0] rd_clear;
  logic [7:0] set_bits;
  logic ot_trip;
  logic hard_trip;
  logic soft_trip;
  logic device_power_field_clr;
  logic power_error_field_set;
  logic cnt_zero;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == ADDR_FAULT_STICKY) || (a == ADDR_INT_MASK) ||
               (a == ADDR_PWR_CTRL_1) || (a == ADDR_SECOND_POWER_CONTROL_REG) ||
               (a == ADDR_PROT_CFG) || (a == ADDR_STATUS);
  endfunction

  afs_fault_detect u_det (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .vdd_low_i(vdd_low_i),
    .vbat_low_i(vbat_low_i),
    .overtemp_i(overtemp_i),
    .brownout_i(brownout_i),
    .asi_clk_err_i(asi_clk_err_i),
    .int_clk_err_i(int_clk_err_i),
    .flt(flt.det)
  );

  assign flt.clka_en = prot_r[BIT_CLKA_DET_EN];
  assign flt.clkb_en = prot_r[BIT_CLKB_DET_EN];

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Completion stalls while the clock enable is low
  assign access = psel_i & penable_i & wait_r & ce_i;
  assign mapped = addr_hit(paddr_i);
  assign pready_o = access;
  assign pslverr_o = pready_o & ~mapped;
  assign prdata_o = rdata_r;
  assign wr_en = ce_i & access & pwrite_i & mapped;
  assign rd_en = ce_i & access & ~pwrite_i & mapped;

  // Wait state marks the first access cycle as done
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wait_r <= 1'b0;
    end else if (ce_i) begin
      wait_r <= psel_i & penable_i & ~wait_r;
    end
  end

  // Read data captured before the completing edge
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (ce_i && psel_i && !pwrite_i && !wait_r) begin
      case (paddr_i)
        ADDR_FAULT_STICKY: rdata_r <= {24'h00_0000, sticky_r};
        ADDR_INT_MASK: rdata_r <= {24'h00_0000, mask_r};
        ADDR_PWR_CTRL_1: rdata_r <= {31'h0000_0000, device_power_field_r};
        ADDR_SECOND_POWER_CONTROL_REG: rdata_r <= {31'h0000_0000, power_error_field_r};
        ADDR_PROT_CFG: rdata_r <= {29'h0000_0000, prot_r};
        ADDR_STATUS: rdata_r <= {23'h00_0000, state_r, analog_r, core_r, mute_r, classd_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sticky fault flags
  // ----------------------------------------------------------------
  // over-temperature only while class-D powered
  assign ot_trip = flt.ot_lvl & classd_r;
  assign set_bits = ({7'h00, flt.uv_evt} << BIT_UNDERVOLT) |
                    ({7'h00, ot_trip} << BIT_OVERTEMP) |
                    ({7'h00, flt.bo_evt} << BIT_BROWNOUT) |
                    ({7'h00, flt.clka_evt} << BIT_CLK_A) |
                    ({7'h00, flt.clkb_evt} << BIT_CLK_B);
  // Clear only what the host actually saw
  assign rd_clear = (rd_en && paddr_i == ADDR_FAULT_STICKY) ? rdata_r[7:0] : 8'h00;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sticky_r <= 8'h00;
    end else if (ce_i) begin
      sticky_r <= ((sticky_r & ~rd_clear) | set_bits) & STICKY_USED;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mask_r <= RST_INT_MASK;
      prot_r <= RST_PROT_CFG;
    end else if (wr_en) begin
      if (paddr_i == ADDR_INT_MASK) begin
        mask_r <= pwdata_i[7:0] & STICKY_USED;
      end
      if (paddr_i == ADDR_PROT_CFG) begin
        prot_r <= pwdata_i[2:0];
      end
    end
  end

  // host sets device power; UV or hard OT clears it
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      device_power_field_r <= 1'b0;
    end else if (ce_i) begin
      if (device_power_field_clr) begin
        device_power_field_r <= 1'b0;
      end else if (wr_en && paddr_i == ADDR_PWR_CTRL_1) begin
        device_power_field_r <= pwdata_i[0];
      end
    end
  end

  // set by brownout or clock shutdown, cleared by write of 0
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      power_error_field_r <= 1'b0;
    end else if (ce_i) begin
      if (power_error_field_set) begin
        power_error_field_r <= 1'b1;
      end else if (wr_en && paddr_i == ADDR_SECOND_POWER_CONTROL_REG && !pwdata_i[0]) begin
        power_error_field_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else if (ce_i) begin
      irq_r <= |(sticky_r & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Supervisor state machine
  // ----------------------------------------------------------------
  // under-voltage is immediate shutdown
  assign hard_trip = flt.uv_lvl | (ot_trip & prot_r[BIT_OT_RETRY_DIS]);
  assign soft_trip = flt.bo_lvl | flt.clka_lvl | flt.clkb_lvl;
  assign cnt_zero = (cnt_r == '0);

  always_comb begin
    state_nxt = state_r;
    device_power_field_clr = 1'b0;
    power_error_field_set = 1'b0;
    case (state_r)
      ST_OFF: begin
        // held down while power error is set
        if (device_power_field_r && !power_error_field_r && !flt.uv_lvl) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (hard_trip) begin
          state_nxt = ST_OFF;
          device_power_field_clr = 1'b1;
        end else if (ot_trip) begin
          state_nxt = ST_RETRY;
        end else if (soft_trip) begin
          state_nxt = ST_MUTE;
        end else if (!device_power_field_r) begin
          state_nxt = ST_OFF;
        end
      end
      ST_MUTE: begin
        if (hard_trip) begin
          state_nxt = ST_OFF;
          device_power_field_clr = 1'b1;
        end else if (ot_trip) begin
          state_nxt = ST_RETRY;
        end else if (cnt_zero) begin
          state_nxt = ST_HOLD;
          power_error_field_set = 1'b1;
        end
      end
      ST_RETRY: begin
        if (flt.uv_lvl || prot_r[BIT_OT_RETRY_DIS] || !device_power_field_r) begin
          state_nxt = ST_OFF;
          device_power_field_clr = flt.uv_lvl | prot_r[BIT_OT_RETRY_DIS];
        end else if (cnt_zero) begin
          state_nxt = ST_RUN;
        end
      end
      ST_HOLD: begin
        // leave once host clears power error
        if (!power_error_field_r) begin
          state_nxt = ST_OFF;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= ST_OFF;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  // Soft-mute and retry timer
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (ce_i) begin
      if (state_r == ST_RUN && state_nxt == ST_MUTE) begin
        cnt_r <= CNT_W'(SOFT_MUTE_CYC - 1);
      end else if (state_r != ST_RETRY && state_nxt == ST_RETRY) begin
        cnt_r <= CNT_W'(RETRY_CYCLES - 1);
      end else if (!cnt_zero) begin
        cnt_r <= cnt_r - CNT_W'(1);
      end
    end
  end

  // Cause of a soft shutdown
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cause_bo_r <= 1'b0;
      cause_clka_r <= 1'b0;
    end else if (ce_i && state_r == ST_RUN && state_nxt == ST_MUTE) begin
      cause_bo_r <= flt.bo_lvl;
      cause_clka_r <= flt.clka_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Power and mute outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      classd_r <= 1'b0;
      mute_r <= 1'b1;
    end else if (ce_i) begin
      // class-D kept on through the soft mute
      classd_r <= (state_nxt == ST_RUN) || (state_nxt == ST_MUTE);
      mute_r <= (state_nxt != ST_RUN);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      core_r <= 1'b0;
      analog_r <= 1'b0;
    end else if (ce_i) begin
      if (state_nxt == ST_RUN) begin
        core_r <= 1'b1;
        analog_r <= 1'b1;
      end else if (state_r == ST_MUTE && state_nxt == ST_HOLD) begin
        // core off on serial clock fault or brownout
        core_r <= core_r & ~(cause_bo_r | cause_clka_r);
        analog_r <= analog_r & ~cause_bo_r;
      end else if (state_nxt == ST_OFF && !device_power_field_r) begin
        core_r <= 1'b0;
        analog_r <= 1'b0;
      end
    end
  end

  assign classd_en_o = classd_r;
  assign audio_mute_o = mute_r;
  assign core_en_o = core_r;
  assign analog_en_o = analog_r;
  assign irq_o = irq_r;

endmodule

// *** tb/afs_fault_src.sv ***
// Purpose: Supply comparators and clock monitors ahead of the supervisor.
// Assumes: Supply levels given in millivolts.
// Notes: One register stage of comparator delay.
`timescale 1ns/1ps
module afs_fault_src #(
  parameter logic [11:0] BO_MV = 12'ha8c
)(
  input wire logic mclk_i,
  input wire logic [11:0] vdd_mv_i,
  input wire logic [11:0] vbat_mv_i,
  input wire logic hot_i,
  input wire logic [1:0] clk_bad_i,
  output logic vdd_low_o = 1'b0,
  output logic vbat_low_o = 1'b0,
  output logic overtemp_o = 1'b0,
  output logic brownout_o = 1'b0,
  output logic asi_clk_err_o = 1'b0,
  output logic int_clk_err_o = 1'b0
);
  always_ff @(posedge mclk_i) begin
    vdd_low_o <= vdd_mv_i < 12'h5dc;
    vbat_low_o <= vbat_mv_i < 12'h960;
    brownout_o <= vbat_mv_i < BO_MV;
    overtemp_o <= hot_i;
    asi_clk_err_o <= clk_bad_i[0];
    int_clk_err_o <= clk_bad_i[1];
  end
endmodule

// *** tb/afs_supervisor_asserts.sv ***
// Purpose: Port checks of the fault supervisor.
// Assumes: ce_i high; fault pins held for many cycles.
// Notes: Bound into every supervisor instance.
`timescale 1ns/1ps
module afs_supervisor_asserts
  import afs_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = RETRY_CYC
)(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic vdd_low_i,
  input wire logic vbat_low_i,
  input wire logic overtemp_i,
  input wire logic brownout_i,
  input wire logic asi_clk_err_i,
  input wire logic int_clk_err_i,
  input wire logic classd_en_o,
  input wire logic audio_mute_o,
  input wire logic analog_en_o,
  input wire logic irq_o
);
  // ----
  // Checks
  // ----
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic [10:0] mute_cnt_r;
  logic quiet;
  assign quiet = !(vdd_low_i | vbat_low_i | overtemp_i | brownout_i | asi_clk_err_i
    | int_clk_err_i);
  // Length of the soft-mute phase
  always_ff @(posedge mclk_i) begin
    if (rst_i || !(audio_mute_o && classd_en_o)) begin
      mute_cnt_r <= 11'h000;
    end else begin
      mute_cnt_r <= mute_cnt_r + 11'h001;
    end
  end
  AST_RST_OUT: assert property ($fell(rst_i) |-> !classd_en_o && audio_mute_o && !irq_o)
    else $error("outputs not at reset values");
  AST_UV_OFF: assert property ($rose(vdd_low_i || vbat_low_i) |-> ##[2:8] !classd_en_o)
    else $error("class-D on after under-voltage");
  AST_OT_OFF: assert property ($rose(overtemp_i) && classd_en_o |-> ##[2:8] !classd_en_o)
    else $error("class-D on after over-temperature");
  AST_OFF_MUTED: assert property (!classd_en_o |-> audio_mute_o)
    else $error("audio unmuted with class-D off");
  AST_BO_SOFT: assert property ($rose(brownout_i) && !audio_mute_o
    |-> ##[2:8] audio_mute_o && analog_en_o)
    else $error("brownout did not soft-mute first");
  AST_CLKB_SOFT: assert property ($rose(int_clk_err_i) && !audio_mute_o
    |-> ##[2:8] audio_mute_o && classd_en_o)
    else $error("clock error did not soft-mute first");
  AST_MUTE_LEN: assert property (mute_cnt_r < 11'd1300)
    else $error("soft mute too long");
  AST_IRQ_CLR: assert property (quiet [*6] ##0 pready_o && !pwrite_i && paddr_i == 8'h00
    |-> ##[1:2] !irq_o)
    else $error("interrupt stays after sticky read");
  AST_ONE_WAIT: assert property (psel_i && !penable_i ##1 psel_i && penable_i
    |-> !pready_o ##1 pready_o)
    else $error("access not one wait state");
  AST_SLVERR: assert property (pready_o |-> pslverr_o == (paddr_i > 8'h14))
    else $error("error response wrong");
  cover property ($fell(analog_en_o));
  cover property ($rose(classd_en_o) ##0 overtemp_i);
  cover property (pslverr_o);
endmodule
bind afs_supervisor afs_supervisor_asserts #(.RETRY_CYCLES(RETRY_CYCLES)) afs_asserts_i (
  .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .vdd_low_i(vdd_low_i), .vbat_low_i(vbat_low_i), .overtemp_i(overtemp_i),
  .brownout_i(brownout_i), .asi_clk_err_i(asi_clk_err_i), .int_clk_err_i(int_clk_err_i),
  .classd_en_o(classd_en_o), .audio_mute_o(audio_mute_o), .analog_en_o(analog_en_o),
  .irq_o(irq_o));

// *** tb/afs_supervisor_tb.sv ***
// Purpose: Directed register-level test of the fault supervisor.
// Assumes: ce_i held high; retry time shortened to 20 cycles.
// Notes: Fault pins come from the comparator model.
`timescale 1ns/1ps
module afs_supervisor_tb
  import afs_pkg::*;
;
  localparam int RT = 20;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, hot = 1'b0, rde;
  logic [1:0] clk_bad = 2'h0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rdq;
  logic [11:0] vdd_mv = 12'h708, vbat_mv = 12'he10;
  logic pready_o, pslverr_o, classd_en_o, audio_mute_o, core_en_o, analog_en_o, irq_o;
  logic vdd_low_i, vbat_low_i, overtemp_i, brownout_i, asi_clk_err_i, int_clk_err_i;
  int bad_count = 0;
  int n_compared = 0;
  wire [4:0] outs = {irq_o, analog_en_o, core_en_o, audio_mute_o, classd_en_o};
  always #4 mclk_i = ~mclk_i;
  afs_supervisor #(.RETRY_CYCLES(RT)) afs_supervisor_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .vdd_low_i(vdd_low_i), .vbat_low_i(vbat_low_i),
    .overtemp_i(overtemp_i), .brownout_i(brownout_i), .asi_clk_err_i(asi_clk_err_i),
    .int_clk_err_i(int_clk_err_i), .classd_en_o(classd_en_o), .audio_mute_o(audio_mute_o),
    .core_en_o(core_en_o), .analog_en_o(analog_en_o), .irq_o(irq_o));
  afs_fault_src afs_fault_src_i (.mclk_i(mclk_i), .vdd_mv_i(vdd_mv), .vbat_mv_i(vbat_mv),
    .hot_i(hot), .clk_bad_i(clk_bad), .vdd_low_o(vdd_low_i), .vbat_low_o(vbat_low_i),
    .overtemp_o(overtemp_i), .brownout_o(brownout_i), .asi_clk_err_o(asi_clk_err_i),
    .int_clk_err_o(int_clk_err_i));
  // ----
  // Tasks
  // ----
  task conclude();
    $display("Counts: %0d compared, %0d bad", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task tmo();
    bad_count++;
    $display("[ERR] %0t wait limit", $time);
    conclude();
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 40);
    if (n >= 40) begin
      tmo();
    end
    rdq = prdata_o;
    rde = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdq, e);
  endtask
  task wt(input int k, input logic v);
    int n;
    n = 0;
    while (outs[k] !== v) begin
      @(posedge mclk_i);
      n++;
      if (n > 3000) begin
        tmo();
      end
    end
    chk({31'h0, outs[k]}, {31'h0, v});
  endtask
  task stay(input int k, input logic v, input int c);
    logic ok;
    ok = 1'b1;
    repeat (c) begin
      @(posedge mclk_i);
      ok &= (outs[k] === v);
    end
    chk({31'h0, ok}, 32'h1);
  endtask
  task tend(input string s);
    $display("Test %s over, %0d bad", s, bad_count);
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(ADDR_INT_MASK, 32'h0);
    rd(ADDR_PROT_CFG, 32'h3);
    rd(ADDR_SECOND_POWER_CONTROL_REG, 32'h0);
    rd(ADDR_STATUS, 32'h12);
    rd(ADDR_FAULT_STICKY, 32'h0);
    rd(8'h18, 32'h0);
    chk({31'h0, rde}, 32'h1);
    apb(1'b1, ADDR_INT_MASK, {24'h0, STICKY_USED});
    rd(ADDR_INT_MASK, {24'h0, STICKY_USED});
    apb(1'b1, ADDR_PWR_CTRL_1, 32'h1);
    wt(1, 1'b0);
    rd(ADDR_STATUS, 32'h2d);
    tend("regs");
    vdd_mv <= 12'h5dc;
    stay(0, 1'b1, 10);
    vdd_mv <= 12'h5db;
    wt(0, 1'b0);
    wt(4, 1'b1);
    rd(ADDR_FAULT_STICKY, 32'h2);
    wt(4, 1'b0);
    rd(ADDR_FAULT_STICKY, 32'h0);
    rd(ADDR_PWR_CTRL_1, 32'h0);
    vdd_mv <= 12'h708;
    apb(1'b1, ADDR_PWR_CTRL_1, 32'h1);
    wt(0, 1'b1);
    tend("uv");
    hot <= 1'b1;
    wt(0, 1'b0);
    stay(0, 1'b0, RT - 4);
    wt(0, 1'b1);
    wt(0, 1'b0);
    hot <= 1'b0;
    wt(0, 1'b1);
    stay(0, 1'b1, 40);
    rd(ADDR_FAULT_STICKY, 32'h10);
    apb(1'b1, ADDR_PROT_CFG, 32'h7);
    hot <= 1'b1;
    wt(0, 1'b0);
    hot <= 1'b0;
    stay(0, 1'b0, 3 * RT);
    rd(ADDR_PWR_CTRL_1, 32'h0);
    rd(ADDR_FAULT_STICKY, 32'h10);
    apb(1'b1, ADDR_PWR_CTRL_1, 32'h1);
    wt(0, 1'b1);
    tend("overtemp");
    apb(1'b1, ADDR_INT_MASK, 32'h8);
    vbat_mv <= 12'ha28;
    wt(1, 1'b1);
    chk({31'h0, analog_en_o}, 32'h1);
    wt(3, 1'b0);
    chk({30'h0, core_en_o, audio_mute_o}, 32'h1);
    wt(4, 1'b1);
    rd(ADDR_SECOND_POWER_CONTROL_REG, 32'h1);
    rd(ADDR_FAULT_STICKY, 32'h8);
    vbat_mv <= 12'he10;
    apb(1'b1, ADDR_SECOND_POWER_CONTROL_REG, 32'h1);
    rd(ADDR_SECOND_POWER_CONTROL_REG, 32'h1);
    stay(0, 1'b0, 10);
    apb(1'b1, ADDR_SECOND_POWER_CONTROL_REG, 32'h0);
    rd(ADDR_SECOND_POWER_CONTROL_REG, 32'h0);
    wt(0, 1'b1);
    tend("brownout");
    for (int i = 0; i < 2; i++) begin
      clk_bad[i] <= 1'b1;
      wt(1, 1'b1);
      chk({31'h0, classd_en_o}, 32'h1);
      stay(0, 1'b1, SOFT_MUTE_CYC - 10);
      wt(0, 1'b0);
      chk({30'h0, core_en_o, irq_o}, {30'h0, i[0], 1'b0});
      rd(ADDR_SECOND_POWER_CONTROL_REG, 32'h1);
      clk_bad[i] <= 1'b0;
      rd(ADDR_FAULT_STICKY, i == 0 ? 32'h20 : 32'h04);
      apb(1'b1, ADDR_SECOND_POWER_CONTROL_REG, 32'h0);
      wt(0, 1'b1);
    end
    apb(1'b1, ADDR_PROT_CFG, 32'h6);
    clk_bad[0] <= 1'b1;
    stay(1, 1'b0, 20);
    clk_bad[0] <= 1'b0;
    rd(ADDR_FAULT_STICKY, 32'h0);
    tend("clock");
    conclude();
  end
endmodule
